// ===== core/pcrt_params.svh
// Register map, field positions, reset values and timing for the time base
`ifndef PCRT_PARAMS_SVH
`define PCRT_PARAMS_SVH

`define PCRT_OFS_PRI_DIV   12'h000
`define PCRT_OFS_SEC_DIV   12'h004
`define PCRT_OFS_PRI_PER   12'h008
`define PCRT_OFS_SEC_PER   12'h00c
`define PCRT_OFS_GEN_CTRL  12'h010
`define PCRT_OFS_AUX_CTRL  12'h014
`define PCRT_OFS_FLT_CTRL  12'h018
`define PCRT_OFS_PHASE     12'h01c
`define PCRT_OFS_DUTY      12'h020
`define PCRT_OFS_OUT_MODE  12'h024
`define PCRT_OFS_STATUS    12'h028

`define PCRT_BIT_EXT_RST   1
`define PCRT_BIT_SEC_SEL   3
`define PCRT_BIT_LOCAL     9
`define PCRT_BIT_GEN_EN    15
`define PCRT_BIT_FINE_DUTY 14
`define PCRT_BIT_FINE_PER  15
`define PCRT_BIT_CYC_LIM   0
`define PCRT_BIT_LIM_POL   9
`define PCRT_LIM_SRC_LO    10
`define PCRT_BIT_SWAP      2

`define PCRT_RST_PER       16'hffff
`define PCRT_RST_WORD      16'h0000

`define PCRT_CLK_NS        4
`define PCRT_FINE_STEP_NS  8
`define PCRT_FINE_STEP_CYC \
	((`PCRT_FINE_STEP_NS + `PCRT_CLK_NS - 1) / `PCRT_CLK_NS)

`endif

// ===== core/pcrt_pkg.sv
// Types shared by the time base generator
package pcrt_pkg;
	typedef enum logic [1:0] {
		MODE_COMP,
		MODE_RED,
		MODE_PP,
		MODE_SPARE
	} pcrt_mode_t;

	typedef struct packed {
		logic [2:0]  priDiv;
		logic [2:0]  secDiv;
		logic [15:0] priPer;
		logic [15:0] secPer;
		logic        extRstEn;
		logic        secSel;
		logic        localSel;
		logic        genEn;
		logic        fineDutyDis;
		logic        finePerDis;
		logic [4:0]  limSrc;
		logic        limPol;
		logic        cycLimEn;
		logic [15:0] phase;
		logic [15:0] duty;
		pcrt_mode_t  outMode;
		logic        swap;
		logic [6:0]  priPre;
		logic [6:0]  secPre;
		logic [15:0] priCnt;
		logic [15:0] secCnt;
		logic [15:0] locCnt;
		logic [15:0] prevEff;
		logic [31:0] limS1;
		logic [31:0] limS2;
		logic        limPrev;
		logic        ppPhase;
		logic        cut;
		logic        hs;
		logic        ls;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pcrt_state_t;
endpackage

// ===== core/pcrt_top.sv
// Generator time base with current reset, output modes and APB registers
//
// What this block does
// - Three-bit divider per master time base slows that master time base and a local counter selected to run from it.
// - Duty-fine disable coarsens duty steps, and phase steps while the generator runs from the master.
// - Period-fine disable coarsens the period step of this generator.
// - With period-fine disable, duty and phase move in 8 ns steps.
// - External reset enable lets the limit signal restart the local counter.
// - Local select runs the generator from its own counter, not the master.
// - Five-bit source field picks which limit input acts as reset.
// - Polarity bit picks which edge of that input triggers the reset.
// - Reset is accepted only while the high output pin is inactive.
// - Reset acts on the leading edge after the on-time has completed.
// - Without external reset the local counter wraps at the phase register.
// - Complementary mode drives low output as inverse of high output while the generator is enabled.
// - Push-pull alternates the pulse between outputs, no complement.
// - Both push-pull phases get exactly the same pulse width.
// - Phase shift adds to the master count so edges come earlier.
// - Phase applies in all master modes and may change while running.
// - Cycle limit ends the active pulse early; the period is unchanged.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pcrt_params.svh"

module pcrt_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Current-limit comparators, asynchronous
	input  wire logic [31:0] limitIn,
	// Power stage
	output logic             highSideOutput,
	output logic             lowSideOutput
);

	pcrt_pkg::pcrt_state_t st;
	pcrt_pkg::pcrt_state_t next_st;

	// Tick when the low div bits of the free counter are all ones
	function automatic logic tickOf(input logic [6:0] pre,
		input logic [2:0] div);
		logic [6:0] mask;
		mask = 7'((8'h1 << div) - 8'h1);
		return (pre & mask) == mask;
	endfunction

	// Drop the fine step when the coarse path is chosen
	function automatic logic [15:0] quant(input logic [15:0] v,
		input logic coarse);
		logic [15:0] m;
		m = ~(16'(`PCRT_FINE_STEP_CYC) - 16'h1);
		return coarse ? (v & m) : v;
	endfunction

	logic        priTick;
	logic        secTick;
	logic        tick;
	logic        coarseDuty;
	logic [15:0] dutyQ;
	logic [15:0] phaseQ;
	logic [15:0] perQ;
	logic [15:0] mCnt;
	logic [16:0] effSum;
	logic [15:0] eff;
	logic        limAct;
	logic        limEdge;
	logic        armed;
	logic        accepted;
	logic        lcWrap;
	logic        perStart;
	logic [15:0] cnt;
	logic        pwm;
	logic        outH;
	logic        outL;
	logic        setup;
	logic        wrEn;
	logic [31:0] rdVal;
	logic        rdHit;

	always_comb begin
		priTick    = tickOf(st.priPre, st.priDiv);
		secTick    = tickOf(st.secPre, st.secDiv);
		tick       = st.secSel ? secTick : priTick;
		coarseDuty = st.fineDutyDis | st.finePerDis;
		dutyQ      = quant(st.duty, coarseDuty);
		mCnt       = st.secSel ? st.secCnt : st.priCnt;
		perQ       = quant(st.secSel ? st.secPer : st.priPer,
			st.finePerDis);
		// Local period lives in the phase register
		phaseQ     = st.localSel ? quant(st.phase, st.finePerDis)
			: quant(st.phase, coarseDuty);
		// Offset count, folded back into one master period
		effSum     = {1'b0, mCnt} + {1'b0, phaseQ};
		if (effSum > {1'b0, perQ})
			eff = 16'(effSum - {1'b0, perQ} - 17'h1);
		else
			eff = effSum[15:0];
		limAct     = st.limS2[st.limSrc] ^ st.limPol;
		limEdge    = limAct & ~st.limPrev;
		// Armed only after the on-time and with the high pin idle
		armed      = st.genEn & st.extRstEn & st.localSel
			& (st.locCnt >= dutyQ) & ~st.hs;
		accepted   = armed & limEdge;
		lcWrap     = tick & (st.locCnt >= phaseQ);
		// Last tick at the top, so phase and cut flip with the new count
		perStart   = st.localSel ? (accepted | lcWrap)
			: (tick & (eff >= perQ));
		cnt        = st.localSel ? st.locCnt : eff;
		pwm        = st.genEn & (cnt < dutyQ) & ~st.cut;
		case (st.outMode)
			pcrt_pkg::MODE_PP: begin
				// Same compare feeds both phases, so widths match
				outH = pwm & ~st.ppPhase;
				outL = pwm & st.ppPhase;
			end
			pcrt_pkg::MODE_RED: begin
				outH = pwm;
				outL = pwm;
			end
			default: begin
				outH = pwm;
				outL = st.genEn & ~pwm;
			end
		endcase
		setup = psel & ~penable;
		wrEn  = psel & penable & pwrite & st.pready;
		rdHit = 1'b1;
		rdVal = 32'h0;
		if (paddr == `PCRT_OFS_PRI_DIV)
			rdVal[2:0] = st.priDiv;
		else if (paddr == `PCRT_OFS_SEC_DIV)
			rdVal[2:0] = st.secDiv;
		else if (paddr == `PCRT_OFS_PRI_PER)
			rdVal[15:0] = st.priPer;
		else if (paddr == `PCRT_OFS_SEC_PER)
			rdVal[15:0] = st.secPer;
		else if (paddr == `PCRT_OFS_GEN_CTRL) begin
			rdVal[`PCRT_BIT_EXT_RST] = st.extRstEn;
			rdVal[`PCRT_BIT_SEC_SEL] = st.secSel;
			rdVal[`PCRT_BIT_LOCAL]   = st.localSel;
			rdVal[`PCRT_BIT_GEN_EN]  = st.genEn;
		end else if (paddr == `PCRT_OFS_AUX_CTRL) begin
			rdVal[`PCRT_BIT_FINE_DUTY] = st.fineDutyDis;
			rdVal[`PCRT_BIT_FINE_PER]  = st.finePerDis;
		end else if (paddr == `PCRT_OFS_FLT_CTRL) begin
			rdVal[`PCRT_LIM_SRC_LO+4:`PCRT_LIM_SRC_LO] = st.limSrc;
			rdVal[`PCRT_BIT_LIM_POL] = st.limPol;
			rdVal[`PCRT_BIT_CYC_LIM] = st.cycLimEn;
		end else if (paddr == `PCRT_OFS_PHASE)
			rdVal[15:0] = st.phase;
		else if (paddr == `PCRT_OFS_DUTY)
			rdVal[15:0] = st.duty;
		else if (paddr == `PCRT_OFS_OUT_MODE) begin
			rdVal[1:0] = st.outMode;
			rdVal[`PCRT_BIT_SWAP] = st.swap;
		end else if (paddr == `PCRT_OFS_STATUS)
			rdVal = {14'h0, st.ls, st.hs, cnt};
		else
			rdHit = 1'b0;
	end

	always_comb begin
		next_st = st;
		next_st.priPre = st.priPre + 7'h1;
		next_st.secPre = st.secPre + 7'h1;
		if (priTick)
			next_st.priCnt = (st.priCnt >= quant(st.priPer,
				st.finePerDis)) ? 16'h0 : st.priCnt + 16'h1;
		if (secTick)
			next_st.secCnt = (st.secCnt >= quant(st.secPer,
				st.finePerDis)) ? 16'h0 : st.secCnt + 16'h1;
		if (accepted | lcWrap)
			next_st.locCnt = 16'h0;
		else if (tick)
			next_st.locCnt = st.locCnt + 16'h1;
		next_st.prevEff = eff;
		// Second stage only reads the first
		next_st.limS1   = limitIn;
		next_st.limS2   = st.limS1;
		next_st.limPrev = limAct;
		if (perStart) begin
			next_st.cut     = 1'b0;
			next_st.ppPhase = ~st.ppPhase;
		end else if (st.cycLimEn & limAct & pwm)
			next_st.cut = 1'b1;
		// Swap only relabels pins; the reset still watches high pin
		next_st.hs = st.swap ? outL : outH;
		next_st.ls = st.swap ? outH : outL;
		next_st.pready  = setup;
		next_st.pslverr = setup & ~rdHit;
		if (setup)
			next_st.prdata = rdVal;
		if (wrEn & ~st.pslverr) begin
			if (paddr == `PCRT_OFS_PRI_DIV)
				next_st.priDiv = pwdata[2:0];
			else if (paddr == `PCRT_OFS_SEC_DIV)
				next_st.secDiv = pwdata[2:0];
			else if (paddr == `PCRT_OFS_PRI_PER)
				next_st.priPer = pwdata[15:0];
			else if (paddr == `PCRT_OFS_SEC_PER)
				next_st.secPer = pwdata[15:0];
			else if (paddr == `PCRT_OFS_GEN_CTRL) begin
				next_st.extRstEn = pwdata[`PCRT_BIT_EXT_RST];
				next_st.secSel   = pwdata[`PCRT_BIT_SEC_SEL];
				next_st.localSel = pwdata[`PCRT_BIT_LOCAL];
				next_st.genEn    = pwdata[`PCRT_BIT_GEN_EN];
			end else if (paddr == `PCRT_OFS_AUX_CTRL) begin
				next_st.fineDutyDis = pwdata[`PCRT_BIT_FINE_DUTY];
				next_st.finePerDis  = pwdata[`PCRT_BIT_FINE_PER];
			end else if (paddr == `PCRT_OFS_FLT_CTRL) begin
				next_st.limSrc =
					pwdata[`PCRT_LIM_SRC_LO+4:`PCRT_LIM_SRC_LO];
				next_st.limPol   = pwdata[`PCRT_BIT_LIM_POL];
				next_st.cycLimEn = pwdata[`PCRT_BIT_CYC_LIM];
			end else if (paddr == `PCRT_OFS_PHASE)
				next_st.phase = pwdata[15:0];
			else if (paddr == `PCRT_OFS_DUTY)
				next_st.duty = pwdata[15:0];
			else if (paddr == `PCRT_OFS_OUT_MODE) begin
				next_st.outMode = pcrt_pkg::pcrt_mode_t'(pwdata[1:0]);
				next_st.swap    = pwdata[`PCRT_BIT_SWAP];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st        <= '0;
			st.priPer <= `PCRT_RST_PER;
			st.secPer <= `PCRT_RST_PER;
			st.phase  <= `PCRT_RST_PER;
			st.duty   <= `PCRT_RST_WORD;
		end else begin
			st <= next_st;
		end
	end

	assign prdata         = st.prdata;
	assign pready         = st.pready;
	assign pslverr        = st.pslverr;
	assign highSideOutput = st.hs;
	assign lowSideOutput  = st.ls;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_div_spacing;
		st.priDiv != 3'h0 && priTick |=> !priTick;
	endproperty
	a_div_spacing: assert property (p_div_spacing)
		else $error("prescaler ticked on two adjacent cycles");

	property p_coarse_duty;
		st.finePerDis |-> dutyQ[0] == 1'b0 && phaseQ[0] == 1'b0;
	endproperty
	a_coarse_duty: assert property (p_coarse_duty)
		else $error("coarse step not applied to duty or phase");

	property p_fine_duty;
		st.fineDutyDis |-> dutyQ[0] == 1'b0
			&& (st.localSel || phaseQ[0] == 1'b0);
	endproperty
	a_fine_duty: assert property (p_fine_duty)
		else $error("duty fine step still in use");

	property p_fine_per;
		st.finePerDis |-> perQ[0] == 1'b0
			&& (!st.localSel || phaseQ[0] == 1'b0);
	endproperty
	a_fine_per: assert property (p_fine_per)
		else $error("period fine step still in use");

	property p_phase_step;
		!st.localSel && tick && !wrEn && phaseQ <= perQ
			&& mCnt < perQ && eff < perQ |=> eff == st.prevEff + 16'h1;
	endproperty
	a_phase_step: assert property (p_phase_step)
		else $error("offset count did not follow master count");

	property p_ext_zero;
		accepted |=> st.locCnt == 16'h0;
	endproperty
	a_ext_zero: assert property (p_ext_zero)
		else $error("accepted reset did not clear local counter");

	property p_hs_blocks;
		limEdge && st.hs && !lcWrap && tick |=> st.locCnt != 16'h0;
	endproperty
	a_hs_blocks: assert property (p_hs_blocks)
		else $error("counter reset while high pin active");

	property p_early_edge;
		limEdge && st.locCnt < dutyQ && !lcWrap && tick
			|=> st.locCnt != 16'h0;
	endproperty
	a_early_edge: assert property (p_early_edge)
		else $error("counter reset before on-time ended");

	property p_local_wrap;
		st.localSel && tick && st.locCnt >= phaseQ
			|=> st.locCnt == 16'h0;
	endproperty
	a_local_wrap: assert property (p_local_wrap)
		else $error("local counter ran past phase period");

	property p_comp;
		st.genEn && st.outMode == pcrt_pkg::MODE_COMP
			|=> st.hs != st.ls;
	endproperty
	a_comp: assert property (p_comp)
		else $error("complementary outputs not inverse");

	property p_pp;
		st.outMode == pcrt_pkg::MODE_PP |=> !(st.hs && st.ls);
	endproperty
	a_pp: assert property (p_pp)
		else $error("push-pull drove both outputs");

	property p_cut;
		st.cycLimEn && limAct && pwm && !perStart && !st.swap && !wrEn
			|=> ##1 !st.hs;
	endproperty
	a_cut: assert property (p_cut)
		else $error("current fault did not end pulse");

	property p_restart;
		accepted && dutyQ != 16'h0 && !st.cycLimEn && !st.swap && !wrEn
			&& st.outMode != pcrt_pkg::MODE_PP
			&& $stable(st.duty) |=> ##1 st.hs;
	endproperty
	a_restart: assert property (p_restart)
		else $error("no on-time after accepted reset");

	c_accept: cover property (accepted);
	c_pp_turn: cover property (st.outMode == pcrt_pkg::MODE_PP
		&& $rose(st.ppPhase));
	c_cut: cover property ($rose(st.cut));
	c_write: cover property (wrEn && paddr == `PCRT_OFS_GEN_CTRL);

endmodule

// ===== sim/pcrt_limit_model.sv
// Current comparator model that drives the limit inputs of one generator
`timescale 1ns/1ps

module pcrt_limit_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Power stage and set-up
	input  wire logic        highSide,
	input  wire logic [4:0]  srcSel,
	input  wire logic [7:0]  delay,
	input  wire logic        early,
	input  wire logic        invert,
	// Comparator outputs
	output logic      [31:0] limitIn
);
	logic [7:0] cnt;
	logic       lvl;
	logic       pat;

	// Unused lines toggle, so a wrong source pick shows up at once
	assign limitIn = ({32{pat}} & ~(32'h1 << srcSel))
		| (32'(lvl ^ invert) << srcSel);

	always @(posedge clk) begin
		pat <= ~pat & ~rst;
		if (rst || highSide) begin
			cnt <= 8'h00;
			lvl <= early & highSide & ~rst;
		end else if (early) begin
			lvl <= 1'h0;
		end else if (cnt < delay) begin
			cnt <= cnt + 8'h01;
		end else begin
			lvl <= 1'h1;
		end
	end
endmodule

// ===== sim/tb_pwm_current_reset_time_base.sv
// Self-checking bench for the generator time base
`timescale 1ns/1ps
`include "pcrt_params.svh"

module tb_pwm_current_reset_time_base;
	localparam logic [31:0] EN  = 32'h1 << `PCRT_BIT_GEN_EN;
	localparam logic [31:0] LOC = 32'h1 << `PCRT_BIT_LOCAL;
	localparam logic [31:0] XR  = 32'h1 << `PCRT_BIT_EXT_RST;
	localparam logic [31:0] POL = 32'h1 << `PCRT_BIT_LIM_POL;
	localparam logic [31:0] CYC = 32'h1 << `PCRT_BIT_CYC_LIM;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] limitIn;
	logic        highSideOutput;
	logic        lowSideOutput;
	logic [4:0]  srcSel = 5'h00;
	logic [7:0]  delay = 8'h04;
	logic        early = 1'h0;
	logic        invert = 1'h0;
	logic [11:0] ad [5] = '{`PCRT_OFS_PHASE, `PCRT_OFS_DUTY,
		`PCRT_OFS_PRI_PER, `PCRT_OFS_GEN_CTRL, 12'h030};
	logic [31:0] rv [5] = '{32'hffff, 32'h0, 32'hffff, 32'h0, 32'h0};
	logic        ev [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
	int          err_count = 0;
	int          samples_checked = 0;
	int          overlap = 0;
	int          same = 0;

	always #2 clk = ~clk;

	always @(posedge clk) begin
		overlap += int'(highSideOutput === 1'h1 && lowSideOutput === 1'h1);
		same += int'(highSideOutput === lowSideOutput);
	end

	pcrt_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .limitIn(limitIn),
		.highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput));

	pcrt_limit_model u_limit (.clk(clk), .rst(rst),
		.highSide(highSideOutput), .srcSel(srcSel), .delay(delay),
		.early(early), .invert(invert), .limitIn(limitIn));

	task automatic complete_run();
		$display("Checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) begin
				err_count++;
				complete_run();
			end
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'h1, a, d, rd, er);
	endtask

	task automatic waitLvl(input bit lo, input logic v, output int c);
		c = 0;
		while ((lo ? lowSideOutput : highSideOutput) !== v) begin
			@(posedge clk);
			c++;
			if (c > 4000) begin
				err_count++;
				complete_run();
			end
		end
	endtask

	// First pulse after a change may be partial, so it is discarded
	task automatic pulse(input bit lo, output int w, output int p);
		int c;
		repeat (2) begin
			waitLvl(lo, 1'h0, c);
			waitLvl(lo, 1'h1, c);
			waitLvl(lo, 1'h0, w);
			waitLvl(lo, 1'h1, c);
		end
		p = w + c;
	endtask

	function automatic int expW(int d, int dv, bit crs);
		return (crs ? d & ~1 : d) << dv;
	endfunction

	function automatic int expP(int p, int dv, bit crs);
		return ((crs ? p & ~1 : p) + 1) << dv;
	endfunction

	initial begin
		int          per, duty, dv, mode, aux, sec, q, src;
		int          w, p, w1, p1, o0, s0;
		logic [31:0] rd;
		logic        er;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		void'($urandom(1370));
		check({highSideOutput, lowSideOutput}, 32'h0);
		foreach (ad[i]) begin
			apb(1'h0, ad[i], 32'h0, rd, er);
			check(rd, rv[i]);
			check(32'(er), 32'(ev[i]));
		end
		for (int i = 0; i < 8; i++) begin
			mode = i % 4;
			sec = i % 2;
			dv = $urandom_range(1);
			per = $urandom_range(29, 10);
			duty = $urandom_range(per - 3, 2);
			aux = i < 4 ? 0 : 1 << (sec ? 15 : 14);
			wr(sec ? `PCRT_OFS_SEC_DIV : `PCRT_OFS_PRI_DIV, 32'(dv));
			wr(sec ? `PCRT_OFS_SEC_PER : `PCRT_OFS_PRI_PER, 32'(per));
			wr(`PCRT_OFS_DUTY, 32'(duty));
			wr(`PCRT_OFS_PHASE, 32'($urandom_range(per)));
			wr(`PCRT_OFS_AUX_CTRL, 32'(aux));
			// Last pass also swaps the pins
			wr(`PCRT_OFS_OUT_MODE, 32'(mode) | 32'(i == 7) << `PCRT_BIT_SWAP);
			wr(`PCRT_OFS_GEN_CTRL, EN | 32'(sec) << `PCRT_BIT_SEC_SEL);
			// Pins lag the enable write by one flop
			repeat (2) @(posedge clk);
			o0 = overlap;
			s0 = same;
			pulse(1'h0, w, p);
			w1 = expW(duty, dv, aux != 0);
			check(w, i == 7 ? expP(per, dv, aux[15]) - w1 : w1);
			check(p, expP(per, dv, aux[15]) << (mode == 2));
			pulse(1'h1, w1, p1);
			check(w1, (mode == 0 || mode == 3) ? p - w : w);
			if (mode == 2)
				check(overlap - o0, 0);
			if (mode == 0 || mode == 3)
				check(same - s0, 0);
		end
		wr(`PCRT_OFS_PRI_DIV, 32'h0);
		wr(`PCRT_OFS_AUX_CTRL, 32'h0);
		wr(`PCRT_OFS_OUT_MODE, 32'h0);
		wr(`PCRT_OFS_DUTY, 32'h8);
		q = $urandom_range(50, 30);
		wr(`PCRT_OFS_PHASE, 32'(q));
		wr(`PCRT_OFS_GEN_CTRL, EN | LOC);
		pulse(1'h0, w, p);
		check(p, q + 1);
		src = $urandom_range(31);
		srcSel <= 5'(src);
		wr(`PCRT_OFS_FLT_CTRL, 32'(src) << `PCRT_LIM_SRC_LO);
		wr(`PCRT_OFS_GEN_CTRL, EN | LOC | XR);
		pulse(1'h0, w, p1);
		check(w, 8);
		check(32'(p1 < q + 1), 1);
		delay <= 8'h09;
		pulse(1'h0, w, p);
		check(p - p1, 5);
		invert <= 1'h1;
		wr(`PCRT_OFS_FLT_CTRL, 32'(src) << `PCRT_LIM_SRC_LO | POL);
		pulse(1'h0, w, p);
		check(p, p1 + 5);
		early <= 1'h1;
		invert <= 1'h0;
		wr(`PCRT_OFS_FLT_CTRL, 32'(src) << `PCRT_LIM_SRC_LO);
		pulse(1'h0, w, p);
		check(p, q + 1);
		wr(`PCRT_OFS_GEN_CTRL, EN);
		wr(`PCRT_OFS_PRI_PER, 32'h28);
		wr(`PCRT_OFS_DUTY, 32'h1e);
		wr(`PCRT_OFS_FLT_CTRL, 32'(src) << `PCRT_LIM_SRC_LO | CYC);
		pulse(1'h0, w, p);
		check(32'(w < 30), 1);
		check(p, 41);
		complete_run();
	end
endmodule
